// *** include/nvp_pkg.sv ***
`default_nettype none
package nvp_pkg;
    localparam int CLK_PERIOD_NS = 20;
    localparam int SCL_PERIOD_NS = 10000;
    localparam int QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
    localparam int NV_WRITE_DURATION_US = 10000;
    // one poll attempt is start, nine bits and stop: about eleven bus clocks
    localparam int POLL_ATTEMPT_NS = 11 * SCL_PERIOD_NS;
    // twice the typical write time, so a slow part is not declared dead
    localparam int POLL_MAX = 2 * (NV_WRITE_DURATION_US * 1000) / POLL_ATTEMPT_NS;

    localparam logic [5:0] DEV_CODE = 6'h28;
    localparam int PAGE_BYTES = 8;

    localparam logic [7:0] POT_POSITION_90K = 8'hf8;
    localparam logic [7:0] POT_POSITION_10K_FIRST = 8'hf9;
    localparam logic [7:0] POT_POSITION_10K_SECOND = 8'hfa;

    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_MADDR = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_DATA = 8'h20;
    localparam int CTRL_GO = 0;
    localparam int CTRL_OP_LSB = 1;
    localparam int CTRL_SEL = 3;
    localparam int CTRL_CNT_LSB = 4;
    localparam int CTRL_WP = 7;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_NACK = 2;
    localparam int STAT_STUCK = 3;
    localparam int STAT_WRAP = 4;
    localparam int STAT_POLLS_LSB = 8;

    typedef enum logic [1:0] {OP_WR, OP_CUR, OP_RAND, OP_RECOV} nvp_op_t;
    typedef enum logic [2:0] {S_IDLE, S_RECOV, S_START, S_BYTE, S_STOP} nvp_st_t;
    typedef enum logic [2:0] {G_DEV, G_MEM, G_WDATA, G_RDEV, G_RDATA, G_POLL} nvp_seg_t;

    typedef struct packed {
        nvp_st_t st;
        nvp_seg_t seg;
        nvp_op_t op;
        logic [15:0] q;
        logic [1:0] ph;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic [2:0] idx;
        logic [2:0] cnt;
        logic [7:0] polls;
        logic [7:0] maddr;
        logic [PAGE_BYTES-1:0][7:0] page_buf;
        logic sel;
        logic wp;
        logic ackn;
        logic post;
        logic busy;
        logic done;
        logic nack;
        logic stuck;
        logic wrapw;
        logic scl;
        logic sda_oe;
        logic sda_o;
        logic [1:0] sync;
        logic [31:0] rdata;
    } nvp_state_t;

    localparam nvp_state_t NVP_RESET = '{st: S_IDLE, seg: G_DEV, op: OP_WR, scl: 1'b1,
        default: '0};
endpackage : nvp_pkg
`default_nettype wire

// *** sim/nvp_dev_model.sv ***
`default_nettype none
module nvp_dev_model
    import nvp_pkg::*;
#(
    parameter int WR_CYC = 200
) (
    input wire logic clk,
    input wire logic scl,
    input wire logic sda,
    input wire logic sel_pin,
    input wire logic wp_pin,
    output logic pull = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [256];
    logic [7:0] pa [PAGE_BYTES];
    logic [7:0] pd [PAGE_BYTES];
    logic [7:0] sh = 8'h00;
    logic [7:0] addr = 8'h00;
    logic ps = 1'b1;
    logic pds = 1'b1;
    logic rdir = 1'b0;
    logic mack = 1'b0;
    int st = 0;
    int bitc = 0;
    int np = 0;
    int timer = 0;
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
    end
    // st: 0 standby, 1 address word, 2 memory address, 3 write data, 4 read data, 5 wait stop
    always @(posedge clk) begin
        ps <= scl;
        pds <= sda;
        if (timer > 0) begin
            timer <= timer - 1;
        end else if (ps && scl && pds && !sda) begin
            st <= 1;
            bitc <= 0;
            np <= 0;
            pull <= 1'b0;
        end else if (ps && scl && !pds && sda) begin
            for (int i = 0; i < np; i++) begin
                if (pa[i] < POT_POSITION_90K || pa[i] > POT_POSITION_10K_SECOND) begin
                    mem[pa[i]] <= pd[i];
                end else if (!wp_pin) begin
                    mem[pa[i]] <= {1'b0, pd[i][6:0]};
                end
            end
            if (np > 0) begin
                timer <= WR_CYC;
            end
            st <= 0;
            np <= 0;
            pull <= 1'b0;
        end else if (st != 0 && !ps && scl) begin
            if (bitc < 8) begin
                if (st != 4) begin
                    sh <= {sh[6:0], sda};
                end
                bitc <= bitc + 1;
            end else begin
                mack <= !sda;
                bitc <= 9;
            end
        end else if (st != 0 && ps && !scl) begin
            if (bitc == 8 && st == 4) begin
                pull <= 1'b0;
            end else if (bitc == 8) begin
                if (st == 1 && (sh[7:2] != DEV_CODE || sh[1] != sel_pin)) begin
                    st <= 0;
                end else begin
                    pull <= 1'b1;
                end
                if (st == 1) begin
                    rdir <= sh[0];
                end
                if (st == 2) begin
                    addr <= sh;
                end
                if (st == 3 && np < PAGE_BYTES) begin
                    pa[np] <= addr;
                    pd[np] <= sh;
                    np <= np + 1;
                    addr <= {addr[7:3], addr[2:0] + 3'h1};
                end
            end else if (bitc == 9) begin
                bitc <= 0;
                pull <= 1'b0;
                if (st == 1 && !rdir) begin
                    st <= 2;
                end else if (st == 2 || st == 3) begin
                    st <= 3;
                end else if (st == 1 || (st == 4 && mack)) begin
                    st <= 4;
                    sh <= mem[addr];
                    pull <= !mem[addr][7];
                    addr <= addr + 8'h01;
                end else begin
                    st <= 5;
                end
            end else if (st == 4) begin
                pull <= !sh[7 - bitc];
            end
        end
    end
endmodule : nvp_dev_model
`default_nettype wire

// *** sim/nvp_host_tb.sv ***
`default_nettype none
module nvp_host_tb
    import nvp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic [31:0] d;
    logic scl, sda_o, sda_oe, wp, pull;
    logic [7:0] expm [256];
    logic [7:0] v;
    logic ce = 1'b1;
    // stands in for a slave that holds data low
    logic hold_low = 1'b0;
    int fails = 0;
    int checks_done = 0;
    int cyc = 0;
    // pull-up on the data line; either party pulls it low
    wire logic sda = !(sda_oe | pull | hold_low);
    always #10 clk = ~clk;
    nvp_host #(.QTR(4), .POLL_LIMIT(8'h06)) u_dut (.clk(clk), .resetn(resetn), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .write_protect(wp));
    nvp_dev_model #(.WR_CYC(200)) u_dev (.clk(clk), .scl(scl), .sda(sda), .sel_pin(1'b1),
        .wp_pin(wp), .pull(pull));
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict
    // ceiling well above the roughly 10k cycles the sequence needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            fails++;
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= w;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    function automatic logic [7:0] exp_val(input logic [7:0] a, input logic [7:0] x,
                                           input logic w);
        if (a < POT_POSITION_90K || a > POT_POSITION_10K_SECOND) begin
            return x;
        end
        return w ? expm[a] : {1'b0, x[6:0]};
    endfunction : exp_val
    task automatic run(input logic [1:0] op, input logic s, input logic [2:0] n, input logic w,
                       input logic [7:0] ma);
        int k;
        wr(REG_STATUS, 32'h1e);
        wr(REG_MADDR, {24'h0, ma});
        wr(REG_CTRL, {24'h0, w, n, s, op, 1'b1});
        k = 0;
        d = '0;
        while (d[STAT_DONE] !== 1'b1 && k < 5000) begin
            rd(REG_STATUS);
            k++;
        end
    endtask : run
    task automatic pw(input logic [7:0] ma, input int n, input logic w, input logic [31:0] est);
        logic [7:0] a;
        a = ma;
        for (int i = 0; i < n; i++) begin
            v = (i == 0) ? 8'h82 : 8'($urandom);
            wr(REG_DATA + 8'(4 * i), {24'h0, v});
            expm[a] = exp_val(a, v, w);
            a = {a[7:3], a[2:0] + 3'h1};
        end
        run(OP_WR, 1'b1, 3'(n - 1), w, ma);
        chk(d & 32'h1f, est);
        chk(32'(d[15:8] != 8'h00), 32'h1);
    endtask : pw
    task automatic rr(input logic [1:0] op, input logic [7:0] ma, input int n);
        logic [7:0] a;
        a = ma;
        run(op, 1'b1, 3'(n - 1), 1'b0, ma);
        chk(d & 32'h0f, 32'h02);
        for (int i = 0; i < n; i++) begin
            rd(REG_DATA + 8'(4 * i));
            chk(d & 32'hff, {24'h0, expm[a]});
            a = a + 8'h01;
        end
    endtask : rr
    task automatic end_test(input string name);
        $display("test %s finished", name);
    endtask : end_test
    initial begin
        v = 8'($urandom(28));
        foreach (expm[i]) expm[i] = 8'h00;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        rd(REG_STATUS);
        chk(d, 32'h0);
        chk({28'h0, scl, sda_oe, sda_o, wp}, 32'h8);
        rd(REG_CTRL);
        chk(d, 32'h0);
        rd(8'h44);
        chk(d, 32'h0);
        // a write while the clock enable is low must not land
        ce <= 1'b0;
        wr(REG_MADDR, 32'h55);
        ce <= 1'b1;
        rd(REG_MADDR);
        chk(d, 32'h0);
        end_test("reset");
        pw(8'hf8, 8, 1'b0, 32'h02);
        rr(OP_RAND, 8'hf8, 8);
        end_test("page");
        // fe, ff then wraps onto f8 inside the page
        pw(8'hfe, 3, 1'b0, 32'h12);
        rr(OP_RAND, 8'hf8, 8);
        end_test("wrap");
        rr(OP_RAND, 8'hff, 2);
        rr(OP_CUR, 8'h01, 1);
        end_test("sequential");
        run(OP_WR, 1'b0, 3'h0, 1'b0, 8'hf9);
        chk(d & 32'h1f, 32'h06);
        pw(8'hf9, 1, 1'b1, 32'h02);
        chk(32'(wp), 32'h1);
        rr(OP_RAND, 8'hf9, 1);
        end_test("select and lock");
        // data stuck low: nine pulses, then give up with stuck set
        hold_low <= 1'b1;
        run(OP_RECOV, 1'b1, 3'h0, 1'b0, 8'h00);
        hold_low <= 1'b0;
        chk(d & 32'h1f, 32'h0a);
        run(OP_RECOV, 1'b1, 3'h0, 1'b0, 8'h00);
        chk(d & 32'h1f, 32'h02);
        end_test("recovery");
        print_verdict();
    end
endmodule : nvp_host_tb
`default_nettype wire

// *** src/nvp_host.sv ***
// The strobed register port was decided locally.
`default_nettype none
module nvp_host
    import nvp_pkg::*;
#(
    parameter int QTR = QTR_CYC,
    parameter logic [7:0] POLL_LIMIT = 8'(POLL_MAX)
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic write_protect
);
    localparam logic [15:0] QTR_LAST = 16'(QTR - 1);

    nvp_state_t r, n;
    logic tick;
    logic rd_byte;
    logic bus_sda;

    function automatic logic [7:0] addr_word(input logic sel, input logic rnw);
        return {DEV_CODE, sel, rnw};
    endfunction : addr_word

    function automatic logic is_data(input logic [7:0] a);
        return a[7:5] == REG_DATA[7:5];
    endfunction : is_data

    function automatic nvp_state_t fin(input nvp_state_t s);
        s.st = S_IDLE;
        s.busy = 1'b0;
        s.done = 1'b1;
        s.scl = 1'b1;
        s.sda_oe = 1'b0;
        return s;
    endfunction : fin

    always_comb begin
        n = r;
        n.rdata = '0;
        n.sync = {r.sync[0], sda_i};
        bus_sda = r.sync[1];
        tick = (r.q == QTR_LAST);
        rd_byte = (r.seg == G_RDATA);
        if (r.st != S_IDLE) begin
            n.q = tick ? '0 : r.q + 16'd1;
        end
        if (reg_rd) begin
            if (reg_addr == REG_CTRL) begin
                n.rdata = {24'h0, r.wp, r.cnt, r.sel, r.op, 1'b0};
            end else if (reg_addr == REG_MADDR) begin
                n.rdata = {24'h0, r.maddr};
            end else if (reg_addr == REG_STATUS) begin
                n.rdata = {16'h0, r.polls, 3'h0, r.wrapw, r.stuck, r.nack, r.done, r.busy};
            end else if (is_data(reg_addr)) begin
                n.rdata = {24'h0, r.page_buf[reg_addr[4:2]]};
            end
        end
        if (reg_wr) begin
            // sticky flags clear here; the engine below may set them again
            if (reg_addr == REG_STATUS) begin
                if (reg_wdata[STAT_DONE]) n.done = 1'b0;
                if (reg_wdata[STAT_NACK]) n.nack = 1'b0;
                if (reg_wdata[STAT_STUCK]) n.stuck = 1'b0;
                if (reg_wdata[STAT_WRAP]) n.wrapw = 1'b0;
            end else if (!r.busy && reg_addr == REG_MADDR) begin
                n.maddr = reg_wdata[7:0];
            end else if (!r.busy && is_data(reg_addr)) begin
                n.page_buf[reg_addr[4:2]] = reg_wdata[7:0];
            end else if (!r.busy && reg_addr == REG_CTRL) begin
                n.op = nvp_op_t'(reg_wdata[CTRL_OP_LSB +: 2]);
                n.sel = reg_wdata[CTRL_SEL];
                n.cnt = reg_wdata[CTRL_CNT_LSB +: 3];
                n.wp = reg_wdata[CTRL_WP];
                if (reg_wdata[CTRL_GO]) begin
                    n.busy = 1'b1;
                    n.done = 1'b0;
                    n.nack = 1'b0;
                    n.stuck = 1'b0;
                    n.post = 1'b0;
                    n.polls = '0;
                    n.q = '0;
                    n.ph = '0;
                    n.bitn = '0;
                    n.ackn = 1'b0;
                    // page writes that cross a page boundary will loop around
                    n.wrapw = (n.op == OP_WR) &&
                        ({1'b0, r.maddr[2:0]} + {1'b0, n.cnt} > 4'd7);
                    n.st = (n.op == OP_RECOV) ? S_RECOV : S_START;
                    n.seg = (n.op == OP_CUR) ? G_RDEV : G_DEV;
                end
            end
        end
        if (tick && r.st != S_IDLE) begin
            n.ph = r.ph + 2'd1;
            unique case (r.st)
                S_IDLE: begin
                end
                S_RECOV: begin
                    if (r.ph == 2'd0) n.sda_oe = 1'b0;
                    if (r.ph == 2'd1) n.scl = 1'b1;
                    if (r.ph == 2'd2) n.ackn = bus_sda;
                    if (r.ph == 2'd3) begin
                        n.scl = 1'b0;
                        if (r.ackn) begin
                            n.st = S_START;
                        end else if (r.bitn == 4'd8) begin
                            n.stuck = 1'b1;
                            n = fin(n);
                        end else begin
                            n.bitn = r.bitn + 4'd1;
                        end
                    end
                end
                S_START: begin
                    if (r.ph == 2'd0) n.sda_oe = 1'b0;
                    if (r.ph == 2'd1) n.scl = 1'b1;
                    if (r.ph == 2'd2) n.sda_oe = 1'b1;
                    if (r.ph == 2'd3) begin
                        n.scl = 1'b0;
                        n.bitn = '0;
                        if (r.op == OP_RECOV) begin
                            n.st = S_STOP;
                        end else begin
                            n.st = S_BYTE;
                            n.sh = addr_word(r.sel, r.seg == G_RDEV);
                        end
                    end
                end
                S_STOP: begin
                    if (r.ph == 2'd0) n.sda_oe = 1'b1;
                    if (r.ph == 2'd1) n.scl = 1'b1;
                    if (r.ph == 2'd2) n.sda_oe = 1'b0;
                    if (r.ph == 2'd3) begin
                        if (r.post) begin
                            n.st = S_START;
                            n.seg = G_POLL;
                        end else begin
                            n = fin(n);
                        end
                    end
                end
                S_BYTE: begin
                    if (r.ph == 2'd0) begin
                        // data moves a quarter period after the clock fell
                        if (r.bitn != 4'd8) begin
                            n.sda_oe = rd_byte ? 1'b0 : ~r.sh[7];
                        end else begin
                            n.sda_oe = rd_byte && (r.idx != r.cnt);
                        end
                    end
                    if (r.ph == 2'd1) n.scl = 1'b1;
                    if (r.ph == 2'd2) begin
                        if (r.bitn != 4'd8 && rd_byte) n.sh = {r.sh[6:0], bus_sda};
                        if (r.bitn == 4'd8) n.ackn = bus_sda;
                    end
                    if (r.ph == 2'd3) begin
                        n.scl = 1'b0;
                        if (r.bitn != 4'd8) begin
                            n.bitn = r.bitn + 4'd1;
                            if (!rd_byte) n.sh = {r.sh[6:0], 1'b0};
                        end else begin
                            n.bitn = '0;
                            if (r.ackn && !rd_byte && r.seg != G_POLL) begin
                                n.nack = 1'b1;
                                n.st = S_STOP;
                            end else begin
                                unique case (r.seg)
                                    G_DEV: begin
                                        n.seg = G_MEM;
                                        n.sh = r.maddr;
                                    end
                                    G_MEM: begin
                                        if (r.op == OP_WR) begin
                                            n.seg = G_WDATA;
                                            n.idx = '0;
                                            n.sh = r.page_buf[0];
                                        end else begin
                                            n.st = S_START;
                                            n.seg = G_RDEV;
                                        end
                                    end
                                    G_WDATA: begin
                                        if (r.idx == r.cnt) begin
                                            n.st = S_STOP;
                                            n.post = 1'b1;
                                        end else begin
                                            n.idx = r.idx + 3'd1;
                                            n.sh = r.page_buf[r.idx + 3'd1];
                                        end
                                    end
                                    G_RDEV: begin
                                        n.seg = G_RDATA;
                                        n.idx = '0;
                                    end
                                    G_RDATA: begin
                                        n.page_buf[r.idx] = r.sh;
                                        if (r.idx == r.cnt) begin
                                            n.st = S_STOP;
                                        end else begin
                                            n.idx = r.idx + 3'd1;
                                        end
                                    end
                                    G_POLL: begin
                                        // every attempt ends in a stop so the bus is left clean
                                        n.st = S_STOP;
                                        if (!r.ackn) begin
                                            n.post = 1'b0;
                                        end else if (r.polls == POLL_LIMIT) begin
                                            n.post = 1'b0;
                                            n.nack = 1'b1;
                                        end else begin
                                            n.polls = r.polls + 8'd1;
                                        end
                                    end
                                    default: n.st = S_STOP;
                                endcase
                            end
                        end
                    end
                end
                default: n = fin(n);
            endcase
        end
        if (!ce) begin
            n = r;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            r <= NVP_RESET;
        end else begin
            r <= n;
        end
    end

    assign reg_rdata = r.rdata;
    assign scl = r.scl;
    assign sda_o = r.sda_o;
    assign sda_oe = r.sda_oe;
    assign write_protect = r.wp;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    logic pulse_end;
    assign pulse_end = ce && tick && r.ph == 2'd3;

    a_sda_stable_high: assert property (
        (r.st == S_BYTE && r.scl) |=> $stable(r.sda_oe))
        else $error("data moved while clock high inside a byte");
    a_start_falls: assert property (
        (ce && tick && r.st == S_START && r.ph == 2'd2) |=> (r.sda_oe && r.scl))
        else $error("start did not pull data low under high clock");
    a_stop_rises: assert property (
        (ce && tick && r.st == S_STOP && r.ph == 2'd2) |=> (!r.sda_oe && r.scl))
        else $error("stop did not release data under high clock");
    a_recov_bound: assert property (
        (r.st == S_RECOV) |-> (r.bitn <= 4'd8 && !r.sda_oe))
        else $error("recovery ran past nine clocks or drove data");
    a_addr_word: assert property (
        (pulse_end && r.st == S_START && r.op != OP_RECOV)
        |=> (r.st == S_BYTE && r.sh == addr_word(r.sel, r.seg == G_RDEV)))
        else $error("address word not loaded after start");
    a_ack_release: assert property (
        (r.st == S_BYTE && r.bitn == 4'd8 && !rd_byte && r.ph != 2'd0) |-> !r.sda_oe)
        else $error("master drove data in the device ack slot");
    a_page_limit: assert property (
        (r.busy && r.seg == G_WDATA) |-> (r.idx <= r.cnt))
        else $error("page write sent more bytes than asked");
    a_last_nack: assert property (
        (r.st == S_BYTE && rd_byte && r.bitn == 4'd8 && r.idx == r.cnt && r.ph != 2'd0)
        |-> !r.sda_oe)
        else $error("master acked the last read byte");
    a_seq_ack: assert property (
        (r.st == S_BYTE && rd_byte && r.bitn == 4'd8 && r.idx != r.cnt && r.ph != 2'd0)
        |-> r.sda_oe)
        else $error("master failed to ack a middle read byte");
    a_restart_read: assert property (
        (pulse_end && r.st == S_BYTE && r.bitn == 4'd8 && r.seg == G_MEM && !r.ackn
        && r.op == OP_RAND) |=> (r.st == S_START && r.seg == G_RDEV && !r.scl))
        else $error("random read did not issue a repeated start");
    a_poll_after_write: assert property (
        (pulse_end && r.st == S_STOP && r.post) |=> (r.st == S_START && r.seg == G_POLL))
        else $error("no poll followed the write stop");
    a_idle_bus: assert property (
        (r.st == S_IDLE) |-> (r.scl && !r.sda_oe && !r.busy))
        else $error("bus not released while idle");

    c_write_done: cover property (r.busy && r.op == OP_WR ##1 r.done && !r.nack);
    c_rand_read: cover property (r.busy && r.op == OP_RAND ##1 r.done && !r.nack);
    c_poll_retry: cover property (r.seg == G_POLL && r.polls == 8'd2);
    c_recovery: cover property (r.busy && r.op == OP_RECOV ##1 r.done && !r.stuck);
endmodule : nvp_host
`default_nettype wire
